// File: hw/tdec_check_regs.svh
`ifndef TDEC_CHECK_REGS_SVH
`define TDEC_CHECK_REGS_SVH
`define OFS_CTRL 13'h000
`define OFS_FRAME_LEN 13'h004
`define OFS_SUBFRAME_LEN 13'h008
`define OFS_PROLOG_LEN 13'h00C
`define OFS_REL_LEN 13'h010
`define OFS_SNR_THR 13'h014
`define OFS_ITER 13'h018
`define OFS_FAULT 13'h01C
`define OFS_FAULT_CLR 13'h020
`define OFS_FAULT_EN 13'h024
`define OFS_STATE 13'h028
`define OFS_OUTPARAM 13'h02C
`define OFS_INTERLEAVER 13'h030
`define RAM_WINDOW_BIT 12
`define CTRL_MODE_BIT 0
`define CTRL_POS_LSB 1
`define CTRL_OUTPARAM_BIT 3
`define CTRL_START_BIT 4
`define CTRL_LOAD_BIT 5
`define ITER_MAX_LSB 0
`define ITER_MIN_LSB 8
`define RST_CTRL 32'h0000_0000
`define RST_ITER 32'h0000_0108
`define RST_LEN 32'h0000_0000
`define SA_FRAME_MIN 15'd40
`define SA_FRAME_MAX 15'd20730
`define SP_FRAME_MIN 15'd256
`define SP_FRAME_MAX 15'd20480
`define SP_LAST_MIN 15'd128
`define SP_SUB_MAX 15'd20480
`define PROLOG_MIN 8'd4
`define PROLOG_MAX 8'd48
`define SA_REL_MIN 8'd40
`define REL_FULL 8'd128
`define SP_LAST_REL_MIN 8'd64
`define SNR_MAX 8'd100
`define ITER_CYCLES_DEFAULT 16
`endif

// File: hw/tdec_check_pkg.sv
package tdec_check_pkg;
    typedef struct packed {
        logic [12:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avmm_req_t;

    typedef enum logic [1:0] {SUB_FIRST, SUB_MIDDLE, SUB_LAST, SUB_RSVD} subframe_pos_t;

    typedef enum {DEC_IDLE, DEC_RUN} dec_state_t;

    // bit order of the fault register above the summary bit
    typedef struct packed {
        logic iteration_bound_fault_flag;
        logic outparam_misuse_flag;
        logic interleaver_misuse;
        logic snr_fault;
        logic rel_len_fault;
        logic subframe_len_fault;
        logic prolog_len_fault;
        logic frame_len_fault;
        logic forbidden_ram_touch_flag;
    } fault_t;
endpackage

// File: hw/turbo_decoder_config_checker.sv
`timescale 1ns/1ps
`include "tdec_check_regs.svh"
module turbo_decoder_config_checker
    import tdec_check_pkg::*;
#(
    parameter int ITER_CYCLES = `ITER_CYCLES_DEFAULT
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire avmm_req_t bus_req,
    output logic waitrequest,
    output logic [31:0] readdata,
    output logic irq
);
    logic ack;
    logic wr_fire;
    logic rd_fire;
    logic [31:0] ctrl;
    logic [14:0] frame_len;
    logic [14:0] subframe_len;
    logic [7:0] prolog_len;
    logic [7:0] reliability_length;
    logic [7:0] snr_thr;
    logic [4:0] iter_max;
    logic [4:0] iter_min;
    fault_t fault;
    fault_t fault_en;
    fault_t check;
    fault_t clr;
    logic load_pulse;
    logic start_pulse;
    logic ram_touch;
    logic table_write;
    logic running;
    dec_state_t state;
    logic [15:0] cyc_cnt;
    logic [4:0] iter_done;
    logic [4:0] outparam;
    logic [31:0] decoder_fault_register;
    logic [31:0] decoder_state_register;
    logic [31:0] next_readdata;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic fault_t run_checks(input logic shared, input subframe_pos_t pos,
                                          input logic op_en, input logic [14:0] f,
                                          input logic [14:0] sf, input logic [7:0] pl,
                                          input logic [7:0] rl, input logic [7:0] snr,
                                          input logic [4:0] imax, input logic [4:0] imin);
        fault_t r;
        r = '0;
        if (!shared)
        begin
            r.frame_len_fault = (f < `SA_FRAME_MIN) || (f > `SA_FRAME_MAX);
            r.rel_len_fault = (rl <= `SA_REL_MIN) || (rl >= `REL_FULL);
        end
        else if (pos == SUB_LAST)
        begin
            r.frame_len_fault = (f < `SP_LAST_MIN) || (f > `SP_FRAME_MAX);
            r.rel_len_fault = (rl <= `SP_LAST_REL_MIN);
        end
        else
        begin
            r.frame_len_fault = (f < `SP_FRAME_MIN) || (f > `SP_FRAME_MAX)
                                || (f[7:0] != 8'h00);
            r.rel_len_fault = (rl != `REL_FULL);
        end
        r.subframe_len_fault = shared && (sf > `SP_SUB_MAX);
        r.prolog_len_fault = (pl < `PROLOG_MIN) || (pl > `PROLOG_MAX);
        r.snr_fault = (snr > `SNR_MAX);
        r.outparam_misuse_flag = shared && op_en;
        r.iteration_bound_fault_flag = (imin > imax);
        return r;
    endfunction

    // one wait state: readdata is latched together with ack
    assign waitrequest = (bus_req.read || bus_req.write) && !ack;
    assign wr_fire = bus_req.write && ack;
    assign rd_fire = bus_req.read && ack;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack <= 1'b0;
        end
        else
        begin
            ack <= (bus_req.read || bus_req.write) && !ack;
        end
    end

    assign load_pulse = wr_fire && (bus_req.address == `OFS_CTRL)
                        && bus_req.byteenable[0] && bus_req.writedata[`CTRL_LOAD_BIT];
    assign start_pulse = wr_fire && (bus_req.address == `OFS_CTRL)
                         && bus_req.byteenable[0] && bus_req.writedata[`CTRL_START_BIT];
    assign ram_touch = (wr_fire || rd_fire) && bus_req.address[`RAM_WINDOW_BIT];
    assign table_write = wr_fire && (bus_req.address == `OFS_INTERLEAVER);
    assign running = (state == DEC_RUN);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl <= `RST_CTRL;
            frame_len <= 15'h0000;
            subframe_len <= 15'h0000;
            prolog_len <= 8'h00;
            reliability_length <= 8'h00;
            snr_thr <= 8'h00;
            iter_max <= 5'h08;
            iter_min <= 5'h01;
            fault_en <= '0;
        end
        else if (wr_fire)
        begin
            case (bus_req.address)
                `OFS_CTRL: ctrl <= merge(ctrl, bus_req.writedata, bus_req.byteenable)
                                   & 32'h0000_000F;
                `OFS_FRAME_LEN: frame_len <= 15'(merge({17'h0, frame_len},
                                                 bus_req.writedata, bus_req.byteenable));
                `OFS_SUBFRAME_LEN: subframe_len <= 15'(merge({17'h0, subframe_len},
                                                       bus_req.writedata, bus_req.byteenable));
                `OFS_PROLOG_LEN: prolog_len <= 8'(merge({24'h0, prolog_len},
                                                  bus_req.writedata, bus_req.byteenable));
                `OFS_REL_LEN: reliability_length <= 8'(merge({24'h0, reliability_length},
                                                       bus_req.writedata, bus_req.byteenable));
                `OFS_SNR_THR: snr_thr <= 8'(merge({24'h0, snr_thr},
                                            bus_req.writedata, bus_req.byteenable));
                `OFS_ITER:
                begin
                    if (bus_req.byteenable[0])
                    begin
                        iter_max <= bus_req.writedata[`ITER_MAX_LSB +: 5];
                    end
                    if (bus_req.byteenable[1])
                    begin
                        iter_min <= bus_req.writedata[`ITER_MIN_LSB +: 5];
                    end
                end
                `OFS_FAULT_EN: fault_en <= fault_t'(bus_req.writedata[9:1]);
                default: ;
            endcase
        end
    end

    assign check = run_checks(ctrl[`CTRL_MODE_BIT], subframe_pos_t'(ctrl[`CTRL_POS_LSB +: 2]),
                              ctrl[`CTRL_OUTPARAM_BIT], frame_len, subframe_len, prolog_len,
                              reliability_length, snr_thr, iter_max, iter_min);
    assign clr = (wr_fire && (bus_req.address == `OFS_FAULT_CLR))
                 ? fault_t'(bus_req.writedata[9:1]) : '0;

    // config flags follow each load; event flags are sticky, set beats clear
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fault <= '0;
        end
        else
        begin
            fault <= fault & ~clr;
            if (load_pulse)
            begin
                fault.frame_len_fault <= check.frame_len_fault;
                fault.prolog_len_fault <= check.prolog_len_fault;
                fault.subframe_len_fault <= check.subframe_len_fault;
                fault.rel_len_fault <= check.rel_len_fault;
                fault.snr_fault <= check.snr_fault;
                fault.outparam_misuse_flag <= check.outparam_misuse_flag;
                fault.iteration_bound_fault_flag <= check.iteration_bound_fault_flag;
            end
            if (ram_touch && running)
            begin
                fault.forbidden_ram_touch_flag <= 1'b1;
            end
            if (table_write && ctrl[`CTRL_MODE_BIT])
            begin
                fault.interleaver_misuse <= 1'b1;
            end
        end
    end

    assign irq = |(fault & fault_en);

    // decode run model: one iteration per ITER_CYCLES; no early stop criterion
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= DEC_IDLE;
            cyc_cnt <= 16'h0000;
            iter_done <= 5'h00;
            outparam <= 5'h00;
        end
        else
        begin
            case (state)
                DEC_IDLE:
                begin
                    if (start_pulse && (fault == '0))
                    begin
                        state <= DEC_RUN;
                        cyc_cnt <= 16'h0000;
                        iter_done <= 5'h00;
                    end
                end
                DEC_RUN:
                begin
                    if (cyc_cnt == 16'(ITER_CYCLES - 1))
                    begin
                        cyc_cnt <= 16'h0000;
                        iter_done <= iter_done + 5'h01;
                        if ((iter_done + 5'h01 >= iter_max) || (iter_done == 5'h1F))
                        begin
                            state <= DEC_IDLE;
                            if (!ctrl[`CTRL_MODE_BIT])
                            begin
                                outparam <= iter_done + 5'h01;
                            end
                        end
                    end
                    else
                    begin
                        cyc_cnt <= cyc_cnt + 16'h0001;
                    end
                end
                default: state <= DEC_IDLE;
            endcase
        end
    end

    assign decoder_fault_register = {22'h0, fault, |fault};
    assign decoder_state_register = {25'h0, iter_done,
                                     |(fault & ~fault_t'(9'h001)), running};

    always_comb
    begin
        case (bus_req.address)
            `OFS_CTRL: next_readdata = ctrl;
            `OFS_FRAME_LEN: next_readdata = {17'h0, frame_len};
            `OFS_SUBFRAME_LEN: next_readdata = {17'h0, subframe_len};
            `OFS_PROLOG_LEN: next_readdata = {24'h0, prolog_len};
            `OFS_REL_LEN: next_readdata = {24'h0, reliability_length};
            `OFS_SNR_THR: next_readdata = {24'h0, snr_thr};
            `OFS_ITER: next_readdata = {19'h0, iter_min, 3'h0, iter_max};
            `OFS_FAULT: next_readdata = decoder_fault_register;
            `OFS_FAULT_EN: next_readdata = {22'h0, fault_en, 1'b0};
            `OFS_STATE: next_readdata = decoder_state_register;
            `OFS_OUTPARAM: next_readdata = {27'h0, outparam};
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            readdata <= 32'h0000_0000;
        end
        else if (bus_req.read && !ack)
        begin
            readdata <= next_readdata;
        end
    end

    AST_RAM_TOUCH: assert property (@(posedge clk) disable iff (!rstn)
        (ram_touch && running) |=> fault.forbidden_ram_touch_flag)
        else $error("forbidden access not flagged");
    AST_IRQ: assert property (@(posedge clk) disable iff (!rstn)
        (fault.forbidden_ram_touch_flag && fault_en.forbidden_ram_touch_flag) |-> irq)
        else $error("enabled fault without interrupt");
    AST_SA_FRAME: assert property (@(posedge clk) disable iff (!rstn)
        (load_pulse && !ctrl[0] && (frame_len > 15'd20730)) |=> fault.frame_len_fault)
        else $error("long standalone frame not flagged");
    AST_SP_MULT: assert property (@(posedge clk) disable iff (!rstn)
        (load_pulse && ctrl[0] && (ctrl[2:1] != 2'h2) && (frame_len[7:0] != 8'h00))
        |=> fault.frame_len_fault)
        else $error("unaligned sub-frame not flagged");
    AST_SP_LAST: assert property (@(posedge clk) disable iff (!rstn)
        (load_pulse && ctrl[0] && (ctrl[2:1] == 2'h2) && (frame_len >= 15'd128)
         && (frame_len <= 15'd20480)) |=> !fault.frame_len_fault)
        else $error("legal last sub-frame flagged");
    AST_PROLOG: assert property (@(posedge clk) disable iff (!rstn)
        load_pulse |=> (fault.prolog_len_fault
                        == (($past(prolog_len) < 8'd4) || ($past(prolog_len) > 8'd48))))
        else $error("prolog flag wrong");
    AST_SUBFRAME: assert property (@(posedge clk) disable iff (!rstn)
        (load_pulse && ctrl[0] && (subframe_len > 15'd20480)) |=> fault.subframe_len_fault)
        else $error("sub-frame length not flagged");
    AST_REL: assert property (@(posedge clk) disable iff (!rstn)
        (load_pulse && ctrl[0] && (ctrl[2:1] == 2'h0) && (reliability_length != 8'd128))
        |=> fault.rel_len_fault)
        else $error("reliability length not flagged");
    AST_SA_REL: assert property (@(posedge clk) disable iff (!rstn)
        (load_pulse && !ctrl[0] && ((reliability_length <= 8'd40)
         || (reliability_length >= 8'd128))) |=> fault.rel_len_fault)
        else $error("standalone reliability bound not flagged");
    AST_SNR: assert property (@(posedge clk) disable iff (!rstn)
        load_pulse |=> (fault.snr_fault == ($past(snr_thr) > 8'd100)))
        else $error("snr flag wrong");
    AST_INTER: assert property (@(posedge clk) disable iff (!rstn)
        (table_write && ctrl[0]) |=> fault.interleaver_misuse)
        else $error("interleaver misuse not flagged");
    AST_OUTPARAM: assert property (@(posedge clk) disable iff (!rstn)
        (load_pulse && ctrl[0] && ctrl[3]) |=> fault.outparam_misuse_flag)
        else $error("output parameter misuse not flagged");
    AST_ITER: assert property (@(posedge clk) disable iff (!rstn)
        (load_pulse && (iter_min > iter_max)) |=> fault.iteration_bound_fault_flag)
        else $error("iteration bounds not flagged");
    AST_SUMMARY: assert property (@(posedge clk) disable iff (!rstn)
        decoder_fault_register[0] == (fault != '0))
        else $error("summary bit wrong");
    AST_STATE_ERR: assert property (@(posedge clk) disable iff (!rstn)
        fault.frame_len_fault |-> decoder_state_register[1])
        else $error("configuration error not shown in state");
    AST_STICKY: assert property (@(posedge clk) disable iff (!rstn)
        (fault.forbidden_ram_touch_flag && !clr.forbidden_ram_touch_flag)
        |=> fault.forbidden_ram_touch_flag)
        else $error("flag dropped without clear");
    AST_NO_START: assert property (@(posedge clk) disable iff (!rstn)
        (start_pulse && !running && (fault != '0)) |=> !running)
        else $error("decode started with a fault pending");

    COV_RUN: cover property (@(posedge clk) disable iff (!rstn) $rose(running));
    COV_TOUCH: cover property (@(posedge clk) disable iff (!rstn) ram_touch && running);
    COV_LOAD_ERR: cover property (@(posedge clk) disable iff (!rstn)
        load_pulse ##1 fault.frame_len_fault);
    COV_IRQ: cover property (@(posedge clk) disable iff (!rstn) $rose(irq));
    COV_SHARED_LOAD: cover property (@(posedge clk) disable iff (!rstn) load_pulse && ctrl[0]);
endmodule

// File: sim/avmm_host.sv
`timescale 1ns/1ps
`include "tdec_check_regs.svh"
module avmm_host
    import tdec_check_pkg::*;
(
    input wire logic clk,
    input wire logic waitrequest,
    input wire logic [31:0] readdata,
    output avmm_req_t bus_req
);
    initial bus_req = '0;
    // held until an edge sees waitrequest low; data taken at that edge, no cycle count assumed
    task automatic access(input logic wr, input logic [12:0] addr, input logic [31:0] wdata,
                          output logic [31:0] rdata);
        @(posedge clk);
        bus_req <= '{addr, !wr, wr, wdata, 4'hF};
        @(posedge clk);
        while (waitrequest !== 1'b0)
        begin
            @(posedge clk);
        end
        rdata = readdata;
        bus_req <= '0;
    endtask
    function automatic logic [31:0] pack_tail(input logic [5:0] a, b, c);
        return {14'h0, a, b, c};
    endfunction
    function automatic logic [31:0] pack_scale(input logic [7:0] a, b, c, d);
        return {d, c, b, a};
    endfunction
    // output parameters fetched only once decoding has stopped
    task automatic fetch_outparam(output logic [31:0] q);
        logic [31:0] s;
        s = 32'h1;
        while (s[0] !== 1'b0)
        begin
            access(1'b0, `OFS_STATE, 32'h0, s);
        end
        access(1'b0, `OFS_OUTPARAM, 32'h0, q);
    endtask
endmodule

// File: sim/tb_turbo_decoder_config_checker.sv
`timescale 1ns/1ps
`include "tdec_check_regs.svh"
module tb_turbo_decoder_config_checker;
    import tdec_check_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    avmm_req_t bus_req;
    logic waitrequest;
    logic [31:0] readdata;
    logic irq;
    int bad_count = 0;
    int compares = 0;
    int seed = 32'h4d3a;
    logic [31:0] q;
    logic [9:0] exp_fault = '0;
    logic [9:0] fault_en = '0;
    logic exp_run = 1'b0;
    int fr[12] = '{39, 40, 127, 128, 255, 256, 257, 512, 20480, 20481, 20730, 20731};
    int pr[4] = '{3, 4, 48, 49};
    int rr[6] = '{39, 40, 64, 65, 128, 129};
    always #5 clk = ~clk;
    turbo_decoder_config_checker #(.ITER_CYCLES(2)) u_turbo_decoder_config_checker (
        .clk(clk), .rstn(rstn), .bus_req(bus_req), .waitrequest(waitrequest),
        .readdata(readdata), .irq(irq));
    avmm_host u_avmm_host (.clk(clk), .waitrequest(waitrequest), .readdata(readdata),
        .bus_req(bus_req));
    task automatic wrap_up();
        if (bad_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t irq %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [31:0] d);
        logic [31:0] unused;
        u_avmm_host.access(1'b1, a, d, unused);
    endtask
    task automatic rd(input logic [12:0] a, output logic [31:0] d);
        u_avmm_host.access(1'b0, a, 32'h0, d);
    endtask
    function automatic logic [9:0] with_sum(input logic [9:0] f);
        return {f[9:1], |f[9:1]};
    endfunction
    function automatic logic [9:0] checks(input logic sp, input logic [1:0] pos, input logic op,
                                          input int f, sf, pl, rl, snr, imax, imin);
        logic [9:0] e;
        e = '0;
        if (!sp)
            e[2] = f < 40 || f > 20730;
        else if (pos != 2'd2)
            e[2] = f < 256 || f > 20480 || f % 256 != 0;
        else
            e[2] = f < 128 || f > 20480;
        e[3] = pl < 4 || pl > 48;
        e[4] = sp && sf > 20480;
        if (!sp)
            e[5] = rl <= 40 || rl >= 128;
        else if (pos != 2'd2)
            e[5] = rl != 128;
        else
            e[5] = rl <= 64;
        e[6] = snr > 100;
        e[8] = sp && op;
        e[9] = imin > imax;
        return e;
    endfunction
    task automatic check_fault();
        rd(`OFS_FAULT, q);
        cmp_word(q, {22'h0, exp_fault});
        rd(`OFS_STATE, q);
        cmp_word({30'h0, q[1:0]}, {30'h0, |exp_fault[9:2], exp_run});
        @(negedge clk);
        cmp_bit(irq, |(exp_fault & fault_en));
    endtask
    task automatic run_cfg(input logic sp, input logic [1:0] pos, input logic op,
                           input int f, sf, pl, rl, snr, imax, imin);
        logic [9:0] c;
        wr(`OFS_CTRL, {28'h0, op, pos, sp});
        wr(`OFS_FRAME_LEN, 32'(f));
        wr(`OFS_SUBFRAME_LEN, 32'(sf));
        wr(`OFS_PROLOG_LEN, 32'(pl));
        wr(`OFS_REL_LEN, 32'(rl));
        wr(`OFS_SNR_THR, 32'(snr));
        wr(`OFS_ITER, {19'h0, 5'(imin), 3'h0, 5'(imax)});
        wr(`OFS_CTRL, {26'h0, 1'b1, 1'b0, op, pos, sp});
        c = checks(sp, pos, op, f, sf, pl, rl, snr, imax, imin);
        exp_fault = with_sum({c[9:8], exp_fault[7], c[6:2], exp_fault[1], 1'b0});
        check_fault();
    endtask
    initial
    begin
        #300000;
        bad_count++;
        wrap_up();
    end
    initial
    begin
        logic [1:0] pos;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rd(`OFS_CTRL, q);
        cmp_word(q, `RST_CTRL);
        rd(`OFS_ITER, q);
        cmp_word(q, `RST_ITER);
        rd(`OFS_FAULT_EN, q);
        cmp_word(q, 32'h0);
        check_fault();
        wr(13'h0F8, u_avmm_host.pack_tail(6'h3F, 6'h15, 6'h2A));
        wr(`OFS_FAULT, u_avmm_host.pack_scale(8'h20, 8'h21, 8'h22, 8'h23));
        rd(13'h0F8, q);
        cmp_word(q, 32'h0);
        rd(13'h1000, q);
        cmp_word(q, 32'h0);
        check_fault();
        fault_en = 10'h024;
        wr(`OFS_FAULT_EN, 32'h0000_0024);
        rd(`OFS_FAULT_EN, q);
        cmp_word(q, 32'h0000_0024);
        for (int i = 0; i < 60; i++)
        begin
            pos = 2'($unsigned($random(seed)) % 3);
            run_cfg(1'($random(seed)), pos, 1'($random(seed)), fr[$unsigned($random(seed)) % 12],
                    20480 + ($random(seed) & 1), pr[$unsigned($random(seed)) % 4],
                    rr[$unsigned($random(seed)) % 6], 100 + ($random(seed) & 1),
                    $random(seed) & 31, $random(seed) & 31);
        end
        run_cfg(1'b0, 2'd0, 1'b0, 39, 0, 24, 64, 0, 8, 1);
        wr(`OFS_FRAME_LEN, 32'd40);
        check_fault();
        run_cfg(1'b1, 2'd0, 1'b0, 512, 512, 24, 128, 0, 8, 1);
        wr(`OFS_INTERLEAVER, 32'h0000_1234);
        exp_fault = with_sum(exp_fault | 10'h080);
        run_cfg(1'b0, 2'd0, 1'b0, 40, 0, 24, 64, 0, 20, 1);
        fault_en = 10'h3FE;
        wr(`OFS_FAULT_EN, 32'h0000_03FE);
        wr(`OFS_FAULT_CLR, 32'h0000_03FE);
        exp_fault = '0;
        check_fault();
        wr(`OFS_INTERLEAVER, 32'h0000_1234);
        check_fault();
        wr(`OFS_CTRL, 32'h0000_0010);
        rd(`OFS_STATE, q);
        cmp_word({31'h0, q[0]}, 32'h1);
        exp_run = 1'b1;
        rd(13'h1000, q);
        cmp_word(q, 32'h0);
        exp_fault = with_sum(10'h002);
        check_fault();
        u_avmm_host.fetch_outparam(q);
        cmp_word({27'h0, q[4:0]}, 32'd20);
        exp_run = 1'b0;
        wr(`OFS_CTRL, 32'h0000_0010);
        rd(`OFS_STATE, q);
        cmp_word({31'h0, q[0]}, 32'h0);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        exp_fault = '0;
        fault_en = '0;
        check_fault();
        wrap_up();
    end
endmodule
